/* File: src/diskette_control_command_unit.sv */
// control-command unit: seek, recalibrate, read id, sense interrupt status
// assumes drive inputs synchronous to mclk and an avalon-mm master
`timescale 1ns/1ps
`include "dskctl_regs.svh"

// Overview of operation
// - read id stores cylinder, head, sector, size of first good id field
// - no id mark before second index: code 01, missing mark set, end
// - read id, recalibrate and seek raise the interrupt when they end
// - recalibrate clears cylinder, steps outward while track zero is low
// - recalibrate sets seek end and stops once track zero goes high
// - after 79 steps without track zero: seek end and equipment check
// - seek and recalibrate give no result; sense status completes them
// - busy while read id runs and while any register access waits
// - seek direction 1 when present below target, 0 when above
// - step spacing follows the loaded step interval setting
// - after each step compare cylinders; equal sets seek end and stops
// - head address bit reads zero after a seek
// - leaving low power clears cylinder and status
// - interrupt on entering result phase of data commands
// - interrupt at seek end, and on non-dma byte transfer request
// - sense interrupt status drops interrupt, reports code and seek end
// - single density track: 40 ff, 6 sync, gaps 26 and 11
// - seek end with code 00 normal, 01 abnormal; 0 with 11 polling
// - non-dma uses interrupt pacing, dma mode uses dma requests
module diskette_control_command_unit #(
	parameter int STEP_UNIT_CYCLES = `STEP_UNIT_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [`ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// drive
	input wire logic track_zero_input,
	input wire logic index_pulse_input,
	output logic step_direction_output,
	output logic step_output,
	// read channel and data path events
	input wire logic id_field_valid,
	input wire logic [31:0] id_field_data,
	input wire logic result_phase_entry,
	input wire logic data_byte_needed,
	// host side
	output logic interrupt_request,
	output logic dma_request,
	output logic busy
);
	dskctl_pkg::state_t s;
	dskctl_pkg::state_t next_s;
	logic wr;
	logic [2:0] cmd;
	logic [7:0] st0;
	logic [19:0] interval;
	logic [31:0] fmt_word;

	if (STEP_UNIT_CYCLES < 1 || STEP_UNIT_CYCLES > 65535) begin : g_chk
		$error("step unit out of range");
	end

	assign wr = write && s.ack;
	assign cmd = writedata[2:0];
	// head address and drive bits fixed at zero: one drive, head reads 0
	assign st0 = {s.ic, s.se, s.ec, 4'h0};
	// interval shrinks as the setting grows, one unit per step
	assign interval = 20'(({1'b0, ~s.step_interval_setting} + 5'h01) * STEP_UNIT_CYCLES);

	always_comb begin
		unique case (s.fmt)
			2'h0: fmt_word = {`SD_GAP2, `SD_GAP1, `SD_SYNC, `SD_GAP4A};
			2'h2: fmt_word = {`PERP_GAP2, `DD_GAP1, `DD_SYNC, `DD_GAP4A};
			default: fmt_word = {`DD_GAP2, `DD_GAP1, `DD_SYNC, `DD_GAP4A};
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.ack = (read || write) && !s.ack;
		next_s.idx_prev = index_pulse_input;
		if (s.timer != 20'h0) begin
			next_s.timer = s.timer - 20'h1;
		end
		// ----------------------------------------
		// register reads
		// ----------------------------------------
		if (read && !s.ack) begin
			unique case (address)
				`OFS_PARAM: next_s.readdata = {17'h0, s.fmt, s.nd, s.step_interval_setting, s.new_cylinder_number};
				`OFS_STATUS: next_s.readdata = {12'h0, s.phase != dskctl_pkg::st_idle,
					s.phase == dskctl_pkg::st_read_id, s.irq, s.ma, s.present_cylinder_number, st0};
				`OFS_IDFIELD: next_s.readdata = s.id_field;
				default: next_s.readdata = fmt_word;
			endcase
		end
		// ----------------------------------------
		// data path events
		// ----------------------------------------
		if (result_phase_entry) begin
			next_s.irq = 1'b1;
		end
		if (data_byte_needed && s.nd) begin
			next_s.irq = 1'b1;
		end
		// ----------------------------------------
		// command engine
		// ----------------------------------------
		unique case (s.phase)
			dskctl_pkg::st_step_high: begin
				if (s.timer == 20'h0) begin
					next_s.step = 1'b0;
					next_s.steps = s.steps + 7'h1;
					if (!s.recal) begin
						next_s.present_cylinder_number = s.dir ? s.present_cylinder_number + 8'h1 : s.present_cylinder_number - 8'h1;
					end
					next_s.timer = interval;
					next_s.phase = dskctl_pkg::st_step_wait;
				end
			end
			dskctl_pkg::st_step_wait: begin
				if (s.timer == 20'h0) begin
					if (s.recal && track_zero_input) begin
						next_s = end_seek(next_s, 1'b0);
					end else if (s.recal && s.steps == `RECAL_MAX_STEPS) begin
						next_s = end_seek(next_s, 1'b1);
					end else if (!s.recal && s.present_cylinder_number == s.new_cylinder_number) begin
						next_s = end_seek(next_s, 1'b0);
					end else begin
						next_s.step = 1'b1;
						next_s.timer = 20'(`STEP_PULSE_CYCLES);
						next_s.phase = dskctl_pkg::st_step_high;
					end
				end
			end
			dskctl_pkg::st_read_id: begin
				if (id_field_valid) begin
					next_s.id_field = id_field_data;
					next_s.ic = `IC_NORMAL;
					next_s.irq = 1'b1;
					next_s.phase = dskctl_pkg::st_idle;
				end else if (index_pulse_input && !s.idx_prev) begin
					next_s.idx_count = s.idx_count + 2'h1;
					if (s.idx_count + 2'h1 == `INDEX_LIMIT) begin
						next_s.ic = `IC_ABNORMAL;
						next_s.ma = 1'b1;
						next_s.irq = 1'b1;
						next_s.phase = dskctl_pkg::st_idle;
					end
				end
			end
			default: begin
			end
		endcase
		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (wr && address == `OFS_PARAM) begin
			next_s.new_cylinder_number = writedata[7:0];
			next_s.step_interval_setting = writedata[`PAR_STEP_LSB +: 4];
			next_s.nd = writedata[`PAR_ND_BIT];
			next_s.fmt = writedata[`PAR_FMT_LSB +: 2];
		end
		if (wr && address == `OFS_CMD) begin
			if (cmd == `CMD_SENSE) begin
				// set wins: an event or a command end in this same cycle keeps it pending
				next_s.irq = result_phase_entry || (data_byte_needed && s.nd)
					|| (s.phase != dskctl_pkg::st_idle
					&& next_s.phase == dskctl_pkg::st_idle);
				if (next_s.ic == `IC_POLL) begin
					next_s.ic = `IC_NORMAL;
				end
			end else if (cmd == `CMD_POWER_DOWN) begin
				next_s.low_power = 1'b1;
			end else if (cmd == `CMD_WAKE && s.low_power) begin
				next_s.low_power = 1'b0;
				next_s.present_cylinder_number = 8'h0;
				next_s.ic = `IC_NORMAL;
				next_s.se = 1'b0;
				next_s.ec = 1'b0;
				next_s.ma = 1'b0;
			end else if (s.phase == dskctl_pkg::st_idle && !s.low_power) begin
				next_s.steps = 7'h0;
				next_s.se = 1'b0;
				next_s.ec = 1'b0;
				next_s.ma = 1'b0;
				next_s.recal = cmd == `CMD_RECAL;
				if (cmd == `CMD_SEEK) begin
					next_s.dir = s.present_cylinder_number < s.new_cylinder_number;
					next_s.phase = dskctl_pkg::st_step_wait;
				end else if (cmd == `CMD_RECAL) begin
					next_s.present_cylinder_number = 8'h0;
					next_s.dir = 1'b0;
					next_s.phase = dskctl_pkg::st_step_wait;
				end else if (cmd == `CMD_READ_ID) begin
					next_s.idx_count = 2'h0;
					next_s.phase = dskctl_pkg::st_read_id;
				end
			end
		end
	end

	// every seek or recalibrate end raises the interrupt, so sense always finds a cause
	function automatic dskctl_pkg::state_t end_seek(dskctl_pkg::state_t v, logic fail);
		v.se = 1'b1;
		v.ec = fail;
		v.ic = fail ? `IC_ABNORMAL : `IC_NORMAL;
		v.irq = 1'b1;
		v.phase = dskctl_pkg::st_idle;
		return v;
	endfunction

	always_ff @(posedge mclk) begin
		if (reset) begin
			s <= '0;
			// one polling interrupt follows reset
			s.ic <= `IC_POLL;
			s.irq <= 1'b1;
			s.step_interval_setting <= 4'hf;
		end else begin
			s <= next_s;
		end
	end

	assign readdata = s.readdata;
	assign waitrequest = (read || write) && !s.ack;
	assign step_direction_output = s.dir;
	assign step_output = s.step;
	assign interrupt_request = s.irq;
	assign dma_request = data_byte_needed && !s.nd;
	// seek and recalibrate run in the background, only read id and a waiting register access hold busy
	assign busy = s.phase == dskctl_pkg::st_read_id || waitrequest;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_recal_direction: assert property (s.recal && step_output |-> !step_direction_output)
		else $error("recalibrate stepped inward");
	a_recal_stop_zero: assert property (s.phase == dskctl_pkg::st_step_wait
		&& s.recal && s.timer == 20'h0 && track_zero_input
		|=> s.se && !s.ec && s.irq)
		else $error("recalibrate missed track zero");
	a_recal_limit: assert property (s.recal && s.phase != dskctl_pkg::st_idle
		|-> s.steps <= 7'd79)
		else $error("recalibrate exceeded step limit");
	a_recal_pcn: assert property (s.recal && s.phase != dskctl_pkg::st_idle
		|-> s.present_cylinder_number == 8'h0)
		else $error("cylinder moved during recalibrate");
	a_seek_dir: assert property (wr && address == `OFS_CMD && cmd == `CMD_SEEK
		&& s.phase == dskctl_pkg::st_idle && !s.low_power
		|=> step_direction_output == ($past(s.present_cylinder_number) < $past(s.new_cylinder_number)))
		else $error("seek direction wrong");
	a_step_spacing: assert property ($fell(step_output) |-> !step_output [*2])
		else $error("step pulses too close");
	a_seek_end: assert property (s.phase == dskctl_pkg::st_step_wait
		&& !s.recal && s.timer == 20'h0 && s.present_cylinder_number == s.new_cylinder_number
		|=> s.se && s.irq && s.phase == dskctl_pkg::st_idle)
		else $error("seek did not end on match");
	a_idle_no_step: assert property (s.phase == dskctl_pkg::st_idle
		|-> !step_output)
		else $error("step pulse outside a command");
	a_readid_index: assert property (s.phase == dskctl_pkg::st_read_id
		&& !id_field_valid && index_pulse_input && !s.idx_prev && s.idx_count == 2'h1
		|=> s.ma && s.ic == `IC_ABNORMAL && s.irq)
		else $error("read id index limit missed");
	a_readid_capture: assert property (s.phase == dskctl_pkg::st_read_id
		&& id_field_valid |=> s.id_field == $past(id_field_data))
		else $error("id field not stored");
	a_readid_irq: assert property (s.phase == dskctl_pkg::st_read_id
		&& id_field_valid |=> s.irq && s.ic == `IC_NORMAL)
		else $error("read id end raised no interrupt");
	a_busy_seek: assert property (s.phase == dskctl_pkg::st_step_wait
		&& !waitrequest |-> !busy)
		else $error("busy during seek execution");
	a_head_zero: assert property (read && !s.ack && address == `OFS_STATUS
		|=> readdata[2] == 1'b0)
		else $error("head bit set");
	a_wake_clear: assert property (wr && address == `OFS_CMD && cmd == `CMD_WAKE
		&& s.low_power |=> s.present_cylinder_number == 8'h0 && !s.se)
		else $error("wake did not clear state");
	a_sense_clear: assert property (wr && address == `OFS_CMD && cmd == `CMD_SENSE
		&& !result_phase_entry && !data_byte_needed && s.phase == dskctl_pkg::st_idle
		|=> !interrupt_request)
		else $error("sense left interrupt set");
	a_event_irq: assert property (result_phase_entry |=> interrupt_request)
		else $error("result phase raised no interrupt");
	a_nd_irq: assert property (data_byte_needed && s.nd |=> interrupt_request)
		else $error("non-dma transfer raised no interrupt");

	// ----------------------------------------
	// scenarios reached
	// ----------------------------------------
	c_seek_done: cover property (s.se && !s.recal && s.irq);
	c_recal_fail: cover property (s.ec);
	c_readid_miss: cover property (s.ma);
	c_readid_good: cover property (s.phase == dskctl_pkg::st_read_id && id_field_valid);
	c_sense_clear: cover property (wr && address == `OFS_CMD && cmd == `CMD_SENSE && s.irq);
endmodule

/* File: src/dskctl_pkg.sv */
// types shared by the control unit
// assumes nothing beyond the register header
package dskctl_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_step_high = 2'b01,
		st_step_wait = 2'b10,
		st_read_id = 2'b11
	} phase_t;
	typedef struct packed {
		phase_t phase;
		logic recal;
		logic [7:0] present_cylinder_number;
		logic [7:0] new_cylinder_number;
		logic [3:0] step_interval_setting;
		logic nd;
		logic [1:0] fmt;
		logic [1:0] ic;
		logic se;
		logic ec;
		logic ma;
		logic irq;
		logic low_power;
		logic dir;
		logic step;
		logic [6:0] steps;
		logic [19:0] timer;
		logic [1:0] idx_count;
		logic idx_prev;
		logic [31:0] id_field;
		logic [31:0] readdata;
		logic ack;
	} state_t;
endpackage

/* File: src/dskctl_regs.svh */
// register map, field positions and timing counts of the control unit
// assumes a 20 MHz mclk and byte addresses on the register bus
`ifndef DSKCTL_REGS_SVH
`define DSKCTL_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CMD 4'h0
`define OFS_PARAM 4'h4
`define OFS_STATUS 4'h8
`define OFS_IDFIELD 4'hc
`define OFS_FORMAT 4'h0
`define ADDR_W 4
// ----------------------------------------
// command codes and field positions
// ----------------------------------------
`define CMD_SEEK 3'h1
`define CMD_RECAL 3'h2
`define CMD_READ_ID 3'h3
`define CMD_SENSE 3'h4
`define CMD_POWER_DOWN 3'h5
`define CMD_WAKE 3'h6
`define PAR_STEP_LSB 8
`define PAR_ND_BIT 12
`define PAR_FMT_LSB 13
// ----------------------------------------
// status codes and command limits
// ----------------------------------------
`define IC_NORMAL 2'h0
`define IC_ABNORMAL 2'h1
`define IC_POLL 2'h3
`define RECAL_MAX_STEPS 7'h4f
`define INDEX_LIMIT 2'h2
// ----------------------------------------
// track format byte counts and values
// ----------------------------------------
`define SD_GAP4A 8'h28
`define SD_SYNC 8'h06
`define SD_GAP1 8'h1a
`define SD_GAP2 8'h0b
`define DD_GAP4A 8'h50
`define DD_SYNC 8'h0c
`define DD_GAP1 8'h32
`define DD_GAP2 8'h16
`define PERP_GAP2 8'h29
`define SD_FILL 8'hff
`define DD_FILL 8'h4e
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define STEP_UNIT_US 500
`define STEP_PULSE_NS 1000
`define STEP_PULSE_CYCLES ((`STEP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_UNIT_CYCLES ((`STEP_UNIT_US * 1000) / `CLK_PERIOD_NS)
`endif

/* File: tb/diskette_control_command_unit_bench.sv */
// bench for the control-command unit with a drive model
// assumes STEP_UNIT_CYCLES of 2 to keep step spacing short
`timescale 1ns/1ps
module diskette_control_command_unit_bench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest, track_zero_input, index_pulse_input;
	logic step_direction_output, step_output, interrupt_request, dma_request, busy;
	logic id_field_valid = 1'b0;
	logic [31:0] id_field_data = 32'h0;
	logic result_phase_entry = 1'b0;
	logic data_byte_needed = 1'b0;
	logic load = 1'b0;
	logic [7:0] load_track = 8'h00;
	logic spin = 1'b0;
	logic [7:0] steps, gap;
	logic last_dir;
	logic [31:0] st;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	diskette_control_command_unit #(.STEP_UNIT_CYCLES(2)) dut_u (.mclk(mclk), .reset(reset),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .track_zero_input(track_zero_input),
		.index_pulse_input(index_pulse_input), .step_direction_output(step_direction_output),
		.step_output(step_output), .id_field_valid(id_field_valid),
		.id_field_data(id_field_data), .result_phase_entry(result_phase_entry),
		.data_byte_needed(data_byte_needed), .interrupt_request(interrupt_request),
		.dma_request(dma_request), .busy(busy));
	drive_model drv_u (.mclk(mclk), .load(load), .load_track(load_track), .spin(spin),
		.step_output(step_output), .step_direction_output(step_direction_output),
		.track_zero_input(track_zero_input), .index_pulse_input(index_pulse_input),
		.steps(steps), .last_dir(last_dir), .gap(gap));
	always #25 mclk = ~mclk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			results();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one avalon request held until waitrequest is sampled low
	// only the bench timeout ends a wait that never sees waitrequest low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		st = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task wait_irq;
		int n;
		n = 0;
		while (interrupt_request !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		chk({31'h0, interrupt_request}, 32'h1);
	endtask
	task sense;
		bus(1'b1, 4'h0, 32'h4);
		repeat (2) @(posedge mclk);
		chk({31'h0, interrupt_request}, 32'h0);
	endtask
	task setdrv(input logic [7:0] t);
		@(posedge mclk);
		load <= 1'b1;
		load_track <= t;
		@(posedge mclk);
		load <= 1'b0;
	endtask
	function automatic logic [31:0] par(logic [7:0] c, logic [3:0] s, logic nd, logic [1:0] f);
		return {17'h0, f, nd, s, c};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		bus(1'b0, 4'h8, 32'h0);
		chk({14'h0, st[17:0]}, 32'h200c0);
		sense();
		$display("reset test done");
	endtask
	task t_seek;
		setdrv(8'h00);
		bus(1'b1, 4'h4, par(8'h03, 4'hc, 1'b0, 2'h0));
		bus(1'b1, 4'h0, 32'h1);
		repeat (3) @(posedge mclk);
		chk({31'h0, busy}, 32'h0);
		wait_irq();
		chk({24'h0, steps}, 32'h3);
		chk({31'h0, last_dir}, 32'h1);
		chk({31'h0, (gap >= 8'd28 && gap <= 8'd32)}, 32'h1);
		bus(1'b0, 4'h8, 32'h0);
		chk({16'h0, st[15:0]}, 32'h0320);
		sense();
		setdrv(8'h03);
		bus(1'b1, 4'h4, par(8'h01, 4'hc, 1'b0, 2'h0));
		bus(1'b1, 4'h0, 32'h1);
		wait_irq();
		chk({23'h0, last_dir, steps}, 32'h2);
		sense();
		$display("seek test done");
	endtask
	task t_recal;
		setdrv(8'h02);
		bus(1'b1, 4'h0, 32'h2);
		wait_irq();
		chk({23'h0, last_dir, steps}, 32'h2);
		bus(1'b0, 4'h8, 32'h0);
		chk({16'h0, st[15:0]}, 32'h0020);
		sense();
		setdrv(8'd100);
		bus(1'b1, 4'h0, 32'h2);
		wait_irq();
		chk({24'h0, steps}, 32'd79);
		bus(1'b0, 4'h8, 32'h0);
		chk({24'h0, st[7:0]}, 32'h70);
		sense();
		$display("recal test done");
	endtask
	task t_readid;
		bus(1'b1, 4'h0, 32'h3);
		repeat (4) @(posedge mclk);
		id_field_data <= 32'h05001203;
		id_field_valid <= 1'b1;
		@(posedge mclk);
		id_field_valid <= 1'b0;
		wait_irq();
		bus(1'b0, 4'hc, 32'h0);
		chk(st, 32'h05001203);
		sense();
		spin <= 1'b1;
		bus(1'b1, 4'h0, 32'h3);
		wait_irq();
		bus(1'b0, 4'h8, 32'h0);
		chk({29'h0, st[16], st[7:6]}, 32'h5);
		spin <= 1'b0;
		sense();
		$display("read id test done");
	endtask
	task t_events;
		result_phase_entry <= 1'b1;
		@(posedge mclk);
		result_phase_entry <= 1'b0;
		wait_irq();
		sense();
		bus(1'b1, 4'h4, par(8'h00, 4'hf, 1'b1, 2'h0));
		data_byte_needed <= 1'b1;
		@(posedge mclk);
		data_byte_needed <= 1'b0;
		wait_irq();
		sense();
		bus(1'b1, 4'h4, par(8'h00, 4'hf, 1'b0, 2'h0));
		data_byte_needed <= 1'b1;
		@(posedge mclk);
		chk({31'h0, dma_request}, 32'h1);
		data_byte_needed <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({31'h0, interrupt_request}, 32'h0);
		$display("event test done");
	endtask
	task t_format;
		logic [31:0] exp [4];
		exp = '{32'h0b1a0628, 32'h16320c50, 32'h29320c50, 32'h16320c50};
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, 4'h4, par(8'h00, 4'hf, 1'b0, f[1:0]));
			bus(1'b0, 4'h0, 32'h0);
			chk(st, exp[f]);
		end
		$display("format test done");
	endtask
	task t_power;
		setdrv(8'h00);
		bus(1'b1, 4'h4, par(8'h04, 4'hf, 1'b0, 2'h0));
		bus(1'b1, 4'h0, 32'h1);
		wait_irq();
		sense();
		bus(1'b1, 4'h0, 32'h3);
		id_field_data <= 32'h04000101;
		id_field_valid <= 1'b1;
		@(posedge mclk);
		id_field_valid <= 1'b0;
		wait_irq();
		bus(1'b0, 4'hc, 32'h0);
		chk(st, 32'h04000101);
		sense();
		bus(1'b1, 4'h0, 32'h5);
		repeat (10) @(posedge mclk);
		chk({31'h0, interrupt_request}, 32'h0);
		bus(1'b1, 4'h0, 32'h6);
		bus(1'b0, 4'h8, 32'h0);
		chk({16'h0, st[15:0]}, 32'h0);
		$display("power test done");
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_recal();
		t_seek();
		t_readid();
		t_events();
		t_format();
		t_power();
		results();
	end
endmodule

/* File: tb/drive_model.sv */
// diskette drive seen from the step/direction side
// assumes pins sampled on mclk; bench loads head position and spin
`timescale 1ns/1ps
module drive_model (
	// clock
	input wire logic mclk,
	// bench controls
	input wire logic load,
	input wire logic [7:0] load_track,
	input wire logic spin,
	// drive pins
	input wire logic step_output,
	input wire logic step_direction_output,
	output logic track_zero_input,
	output logic index_pulse_input,
	// observation
	output logic [7:0] steps,
	output logic last_dir,
	output logic [7:0] gap
);
	logic [7:0] track;
	logic [7:0] age;
	logic [7:0] rot;
	logic prev;
	initial begin
		track = 8'h00;
		steps = 8'h00;
		last_dir = 1'b0;
		gap = 8'h00;
		age = 8'h00;
		rot = 8'h00;
		prev = 1'b0;
	end
	// index only while spinning, so a stopped disk gives no pulses
	assign track_zero_input = (track == 8'h00);
	assign index_pulse_input = spin && (rot < 8'h04);
	always @(posedge mclk) begin
		prev <= step_output;
		age <= age + 8'h01;
		rot <= spin ? rot + 8'h01 : 8'h00;
		if (load) begin
			track <= load_track;
			steps <= 8'h00;
		end else if (step_output && !prev) begin
			steps <= steps + 8'h01;
			last_dir <= step_direction_output;
			gap <= age;
			age <= 8'h00;
			// head cannot move out past the stop
			track <= step_direction_output ? track + 8'h01 :
				(track == 8'h00 ? 8'h00 : track - 8'h01);
		end
	end
endmodule
